// ===== iofa_decoder.sv
`timescale 1ns/1ns
`include "iofa_consts.svh"
module iofa_decoder
    import iofa_pkg::*;
(
    input  wire logic          core_clk,          // core clock
    input  wire logic          rst,               // async reset
    input  wire logic          execValid,         // instruction executes this cycle
    input  wire logic [15:0]   instrWord,         // instruction register
    input  wire logic          extendedSetEnable, // configuration bit
    input  wire logic          hasAccessBit,      // byte/bit class opcode
    input  wire logic          hasDestBit,        // byte class opcode
    input  wire logic [3:0]    bankSelectValue,   // bank select register
    input  wire logic [20:0]   topOfReturnStack,  // return address
    output logic [11:0]        dataAddr,          // effective data address
    output logic               destToWorking,     // result goes to working register
    output logic               offsetMode,        // indexed offset used
    output logic               loadPc,            // pc load strobe
    output logic [20:0]        pcLoadValue,       // pc load value
    output logic               popStack,          // return stack pop
    output logic               stallNop,          // forced no-op cycle
    output logic [11:0]        stackFramePointer, // pointer 2 view
    output logic [11:0]        filePointer0,      // pointer 0 view
    output logic [11:0]        filePointer1       // pointer 1 view
);
    iofa_ptr_if ptrBus ();
    iofa_state_type state_reg, state_next;
    logic [11:0] dataAddr_next;
    logic        destToWorking_next, offsetMode_next, loadPc_next;
    logic [20:0] pcLoadValue_next;

    // ----------------------------------------
    // instruction decode
    // ----------------------------------------
    wire isPtrSub    = execValid && state_reg == IOFA_IDLE && instrWord[15:8] == `IOFA_PSUB_PREFIX;
    wire isFrameRet  = isPtrSub && instrWord[7:6] == `IOFA_SEL_FRAME;
    wire [7:0] opnd  = instrWord[7:0];
    wire accessBit   = instrWord[8];
    wire lowOperand  = opnd <= `IOFA_OFFSET_LIMIT;
    // note: applies to any opcode flagged by the core as carrying the access bit
    // gated by execValid so an idle cycle never reports offset mode
    wire useOffset   = execValid && extendedSetEnable && hasAccessBit && !accessBit && lowOperand;
    wire [11:0] offAddr = stackFramePointer + {4'h0, opnd};
    wire [11:0] litAddr = accessBit ? {bankSelectValue, opnd} : {{4{opnd[7]}}, opnd};

    assign ptrBus.writeEn = isPtrSub;
    assign ptrBus.sel     = isFrameRet ? `IOFA_FRAME_PTR_IDX : instrWord[7:6];
    assign ptrBus.literal = instrWord[5:0];
    assign stackFramePointer = ptrBus.ptr2;
    assign filePointer0      = ptrBus.ptr0;
    assign filePointer1      = ptrBus.ptr1;

    iofa_ptr_file ptrFile (
        .core_clk (core_clk),
        .rst      (rst),
        .bus      (ptrBus)
    );

    // ----------------------------------------
    // next values
    // ----------------------------------------
    assign state_next         = isFrameRet ? IOFA_RETNOP : IOFA_IDLE;
    assign dataAddr_next      = useOffset ? offAddr : litAddr;
    assign destToWorking_next = hasDestBit && !instrWord[9];
    assign offsetMode_next    = useOffset;
    assign loadPc_next        = isFrameRet;
    assign pcLoadValue_next   = isFrameRet ? topOfReturnStack : pcLoadValue;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= IOFA_IDLE;
            dataAddr      <= `IOFA_PTR_RESET;
            destToWorking <= 1'b0;
            offsetMode    <= 1'b0;
            loadPc        <= 1'b0;
            pcLoadValue   <= 21'h0_0000;
        end else begin
            state_reg     <= state_next;
            dataAddr      <= dataAddr_next;
            destToWorking <= destToWorking_next;
            offsetMode    <= offsetMode_next;
            loadPc        <= loadPc_next;
            pcLoadValue   <= pcLoadValue_next;
        end
    end
    assign popStack = loadPc;
    assign stallNop = state_reg == IOFA_RETNOP;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_ret_issue;
        isFrameRet;
    endsequence
    sequence s_ret_finish;
        loadPc && stallNop ##1 !stallNop;
    endsequence
    a_return_two_cycles: assert property (@(posedge core_clk) disable iff (rst)
        s_ret_issue |=> s_ret_finish) else $error("return not two cycles");
    a_return_pc_value: assert property (@(posedge core_clk) disable iff (rst)
        isFrameRet |=> pcLoadValue == $past(topOfReturnStack)) else $error("pc not from stack");
    a_ptr_subtract: assert property (@(posedge core_clk) disable iff (rst)
        isPtrSub && instrWord[7:6] == 2'b00 |=> filePointer0 == $past(filePointer0) - $past({6'h00_0, instrWord[5:0]}))
        else $error("pointer subtract wrong");
    a_frame_ret_ptr: assert property (@(posedge core_clk) disable iff (rst)
        isFrameRet |=> stackFramePointer == $past(stackFramePointer) - $past({6'h00_0, instrWord[5:0]})
            && filePointer1 == $past(filePointer1)) else $error("frame subtract wrong");
    a_offset_addr: assert property (@(posedge core_clk) disable iff (rst)
        useOffset |=> dataAddr == $past(offAddr) && offsetMode) else $error("offset address wrong");
    a_high_literal: assert property (@(posedge core_clk) disable iff (rst)
        execValid && opnd > 8'h5F |=> !offsetMode) else $error("high operand offset");
    a_disabled_literal: assert property (@(posedge core_clk) disable iff (rst)
        execValid && !extendedSetEnable && accessBit |=> dataAddr == {$past(bankSelectValue), $past(opnd)})
        else $error("banked address wrong");
    a_dest_select: assert property (@(posedge core_clk) disable iff (rst)
        hasDestBit && instrWord[9] |=> !destToWorking) else $error("dest bit wrong");

    // ----------------------------------------
    // pointer file checks
    // ----------------------------------------
    // a subtract offered in the no-op cycle must leave every pointer alone
    sequence s_refused_sub;
        stallNop && execValid && instrWord[15:8] == `IOFA_PSUB_PREFIX;
    endsequence

    sequence s_ptrs_held;
        $stable(filePointer0) && $stable(filePointer1) && $stable(stackFramePointer);
    endsequence

    a_ptr1_subtract: assert property (@(posedge core_clk) disable iff (rst)
        isPtrSub && instrWord[7:6] == 2'b01 |=> filePointer1 == $past(filePointer1) - $past({6'h00, instrWord[5:0]}))
        else $error("pointer one subtract wrong");

    a_ptr2_subtract: assert property (@(posedge core_clk) disable iff (rst)
        isPtrSub && instrWord[7:6] == 2'b10 |=>
            stackFramePointer == $past(stackFramePointer) - $past({6'h00, instrWord[5:0]}))
        else $error("pointer two subtract wrong");

    a_stall_refused: assert property (@(posedge core_clk) disable iff (rst)
        s_refused_sub |=> s_ptrs_held) else $error("subtract taken in no-op cycle");

    a_ptrs_quiet: assert property (@(posedge core_clk) disable iff (rst)
        !isPtrSub |=> s_ptrs_held) else $error("pointer changed without subtract");

    // wrap is expected: a literal above the pointer lands near the top
    a_ptr_wrap: assert property (@(posedge core_clk) disable iff (rst)
        isPtrSub && instrWord[7:6] == 2'b00 && {6'h00, instrWord[5:0]} > filePointer0 |=>
            filePointer0 > $past(filePointer0)) else $error("pointer did not wrap");

    // ----------------------------------------
    // return sequencing checks
    // ----------------------------------------
    a_pop_pulse: assert property (@(posedge core_clk) disable iff (rst)
        loadPc |=> !loadPc) else $error("pc load longer than one cycle");

    a_pop_follows: assert property (@(posedge core_clk) disable iff (rst)
        popStack == loadPc) else $error("pop not aligned with pc load");

    a_nop_ends: assert property (@(posedge core_clk) disable iff (rst)
        stallNop |=> !stallNop) else $error("no-op cycle repeated");

    // ----------------------------------------
    // address path checks
    // ----------------------------------------
    a_access_bank: assert property (@(posedge core_clk) disable iff (rst)
        execValid && !accessBit && !lowOperand |=>
            dataAddr == {{4{$past(opnd[7])}}, $past(opnd)} && !offsetMode)
        else $error("access bank address wrong");

    a_offset_sum: assert property (@(posedge core_clk) disable iff (rst)
        useOffset |=> dataAddr == $past(stackFramePointer) + {4'h0, $past(opnd)})
        else $error("offset sum wrong");

    a_zero_frame: assert property (@(posedge core_clk) disable iff (rst)
        useOffset && stackFramePointer == 12'h000 |=> dataAddr == {4'h0, $past(opnd)})
        else $error("zero frame not legacy");

    a_ext_off: assert property (@(posedge core_clk) disable iff (rst)
        execValid && !extendedSetEnable |=> !offsetMode) else $error("offset mode while disabled");

    a_ext_on: assert property (@(posedge core_clk) disable iff (rst)
        execValid && extendedSetEnable && hasAccessBit && !accessBit && lowOperand |=> offsetMode)
        else $error("offset mode missing");

    a_class_only: assert property (@(posedge core_clk) disable iff (rst)
        execValid && !hasAccessBit |=> !offsetMode) else $error("offset on wrong class");

    // ----------------------------------------
    // destination checks
    // ----------------------------------------
    a_dest_working: assert property (@(posedge core_clk) disable iff (rst)
        hasDestBit && !instrWord[9] |=> destToWorking) else $error("dest working wrong");

    a_dest_nonbyte: assert property (@(posedge core_clk) disable iff (rst)
        !hasDestBit |=> !destToWorking) else $error("dest set for non-byte op");
endmodule : iofa_decoder

// ===== iofa_consts.svh
`ifndef IOFA_CONSTS_SVH
`define IOFA_CONSTS_SVH
// ----------------------------------------
// opcode fields and pointer reset value
// ----------------------------------------
`define IOFA_PSUB_PREFIX     8'hE9
`define IOFA_SEL_FRAME       2'b11
`define IOFA_OFFSET_LIMIT    8'h5F
`define IOFA_FRAME_PTR_IDX   2'd2
`define IOFA_PTR_RESET       12'h000
`endif

// ===== iofa_pkg.sv
package iofa_pkg;
    typedef enum logic [1:0] {
        IOFA_IDLE   = 2'b00,
        IOFA_RETNOP = 2'b01
    } iofa_state_type;
    typedef logic [11:0] iofa_addr_type;
endpackage : iofa_pkg

// ===== iofa_ptr_if.sv
`timescale 1ns/1ns
interface iofa_ptr_if;
    logic        writeEn;
    logic [1:0]  sel;
    logic [5:0]  literal;
    logic [11:0] ptr0;
    logic [11:0] ptr1;
    logic [11:0] ptr2;
    modport owner (input writeEn, input sel, input literal, output ptr0, output ptr1, output ptr2);
    modport user  (output writeEn, output sel, output literal, input ptr0, input ptr1, input ptr2);
endinterface : iofa_ptr_if

// ===== iofa_ptr_file.sv
`timescale 1ns/1ns
`include "iofa_consts.svh"
module iofa_ptr_file
    import iofa_pkg::*;
(
    input wire logic core_clk, // core clock
    input wire logic rst,      // async reset
    iofa_ptr_if.owner bus      // pointer access
);
    iofa_addr_type ptr_reg [3];
    // modulo-width subtract, status untouched
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ptr_reg[0] <= `IOFA_PTR_RESET;
            ptr_reg[1] <= `IOFA_PTR_RESET;
            ptr_reg[2] <= `IOFA_PTR_RESET;
        end else if (bus.writeEn && bus.sel != 2'b11) begin
            ptr_reg[bus.sel] <= ptr_reg[bus.sel] - {6'h00_0, bus.literal};
        end
    end
    assign bus.ptr0 = ptr_reg[0];
    assign bus.ptr1 = ptr_reg[1];
    assign bus.ptr2 = ptr_reg[2];
endmodule : iofa_ptr_file

// ===== iofa_ret_stack_model.sv
`timescale 1ns/1ns
module iofa_ret_stack_model (
    input  wire logic        core_clk,        // core clock
    input  wire logic        rst,             // async reset
    input  wire logic        popStack,        // pop strobe
    output logic      [20:0] topOfReturnStack // return address
);
    // each pop shows a fresh address, so a stale reuse is caught
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) topOfReturnStack <= 21'h0_0100;
        else if (popStack) topOfReturnStack <= topOfReturnStack + 21'h0_1357;
    end
endmodule : iofa_ret_stack_model

// ===== tb_indexed_offset_addressing.sv
`timescale 1ns/1ns
module tb_indexed_offset_addressing;
    import iofa_pkg::*;
    logic          core_clk = 0, rst = 1, execValid = 0, hasAccessBit = 0, hasDestBit = 0;
    logic          extendedSetEnable = 0, destToWorking, offsetMode, loadPc, popStack, stallNop;
    logic [15:0]   instrWord = 0;
    logic [3:0]    bankSelectValue = 0;
    logic [20:0]   topOfReturnStack, pcLoadValue, eTos;
    iofa_addr_type dataAddr, stackFramePointer, filePointer0, filePointer1, eAddr, eP [3];
    iofa_addr_type ptr [3] = '{0, 0, 0};
    logic          eVld = 0, eAcc, eOff, eDw, eLd, mStall = 0;
    int            failures = 0, checksDone = 0, seed = 32'h0000_ce9c, r;
    iofa_decoder iofa_decoder_inst (.core_clk, .rst, .execValid, .instrWord, .extendedSetEnable, .hasAccessBit,
        .hasDestBit, .bankSelectValue, .topOfReturnStack, .dataAddr, .destToWorking, .offsetMode, .loadPc,
        .pcLoadValue, .popStack, .stallNop, .stackFramePointer, .filePointer0, .filePointer1);
    iofa_ret_stack_model iofa_ret_stack_model_inst (.core_clk, .rst, .popStack, .topOfReturnStack);
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input string n, input logic [20:0] e, input logic [20:0] g);
        checksDone++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checksDone, failures);
        if (failures == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // expectations are latched after the sampling edge so the next issue cannot overwrite them
    task automatic op(input logic [15:0] iw, input logic acc, dst, x, input logic [3:0] b);
        logic [7:0]    f;
        logic          off, ld, sub;
        iofa_addr_type a;
        f = iw[7:0];
        off = acc && x && !iw[8] && f <= 8'h5F;
        a = off ? ptr[2] + f : (iw[8] ? {b, f} : {{4{f[7]}}, f});
        sub = !acc && iw[15:8] == 8'hE9 && !mStall;
        ld = sub && iw[7:6] == 2'b11;
        if (sub) ptr[ld ? 2 : iw[7:6]] -= iw[5:0];
        mStall = ld;
        instrWord <= iw;
        hasAccessBit <= acc;
        hasDestBit <= dst;
        extendedSetEnable <= x;
        bankSelectValue <= b;
        execValid <= 1'b1;
        @(posedge core_clk);
        eAcc = acc;
        eOff = off;
        eDw = dst && !iw[9];
        eLd = ld;
        eAddr = a;
        eTos = topOfReturnStack;
        eP = ptr;
        eVld = 1;
    endtask : op
    always @(negedge core_clk) begin
        if (eVld) begin
            chk("loadPc", eLd, loadPc);
            chk("popStack", eLd, popStack);
            chk("stallNop", eLd, stallNop);
            chk("ptr0", eP[0], filePointer0);
            chk("ptr1", eP[1], filePointer1);
            chk("ptr2", eP[2], stackFramePointer);
            if (eLd) chk("pcLoadValue", eTos, pcLoadValue);
            if (eAcc) chk("dataAddr", eAddr, dataAddr);
            if (eAcc) chk("offsetMode", eOff, offsetMode);
            if (eAcc) chk("destToWorking", eDw, destToWorking);
        end
    end
    // ----------------------------------------
    // stimulus
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        op(16'h2420, 1, 1, 1, 4'h3);
        op(16'hE9C5, 0, 0, 0, 4'h0);
        op(16'hE901, 0, 0, 0, 4'h0);
        $display("test frame return done");
        for (int i = 0; i < 5; i++) op({8'hE9, i[1:0], 6'h3F}, 0, 0, 0, 4'h0);
        op(16'h225F, 1, 1, 1, 4'h0);
        op(16'h2060, 1, 0, 1, 4'h0);
        op(16'h21F0, 1, 1, 1, 4'hA);
        op(16'h2085, 1, 0, 0, 4'h0);
        $display("test corners done");
        repeat (300) begin
            r = $random(seed);
            if (r[31] || mStall) op({8'hE9, r[7:0]}, 0, 0, 0, 4'h0);
            else op({4'h2, r[11:0]}, 1, r[12], r[13], r[17:14]);
        end
        execValid <= 1'b0;
        @(posedge core_clk);
        eVld = 0;
        $display("test random done");
        tally_and_finish();
    end
    initial begin
        #20000;
        failures++;
        tally_and_finish();
    end
endmodule : tb_indexed_offset_addressing
